// File: cpu_bus_pkg.sv
// Address map, timing and encodings shared by the CPU bus access logic
package cpu_bus_pkg;
  localparam logic [15:0] ROM_END        = 16'h7FFF;
  localparam logic [15:0] VEC_END        = 16'h002F;
  localparam logic [15:0] ROM_START      = 16'h0030;
  localparam logic [15:0] IO_LO_START    = 16'hF770;
  localparam logic [15:0] IO_LO_END      = 16'hF77F;
  localparam logic [15:0] RAM_START      = 16'hFB80;
  localparam logic [15:0] RAM_END        = 16'hFF7F;
  localparam logic [15:0] RSV_START      = 16'hFF80;
  localparam logic [15:0] RSV_END        = 16'hFF9F;
  localparam logic [15:0] IO_HI_START    = 16'hFFA0;
  localparam int          RAM_BYTES      = 1024;
  localparam int          RAM_AW         = 9;
  localparam int          IO_WIDTH       = 8;
  localparam logic [1:0]  MEM_STATES     = 2'h2;
  localparam logic [1:0]  IO_LO_STATES   = 2'h3;
  localparam logic [1:0]  IO_FAST_STATES = 2'h2;
  localparam logic [1:0]  IO_SLOW_STATES = 2'h3;
  localparam logic [15:0] PORTC_DATA_ADDR = 16'hFFD6;
  localparam logic [15:0] PORTC_DIR_ADDR  = 16'hFFE6;
  localparam logic [15:0] TIMER_ADDR      = 16'hFFB0;
  localparam logic [7:0]  WO_READ         = 8'hFF;
  localparam logic [7:0]  LATCH_RST       = 8'h00;
  localparam logic [7:0]  DIR_RST         = 8'h00;
  localparam logic [7:0]  RELOAD_RST      = 8'hFF;
  localparam logic [7:0]  FILL_BYTE       = 8'h00;

  typedef enum logic [2:0] {
    BIT_NONE = 3'h0, BIT_SET = 3'h1, BIT_CLEAR = 3'h2,
    BIT_INVERT = 3'h3, BIT_STORE = 3'h4, BIT_STORE_INV = 3'h5
  } bitop_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_ACCESS = 3'b010, ST_RMW = 3'b100
  } state_t;

  typedef enum logic [2:0] {
    RG_ROM = 3'h0, RG_RAM = 3'h1, RG_IOLO = 3'h2, RG_IOHI = 3'h3, RG_RSV = 3'h4
  } region_t;

  function automatic region_t regionOf(input logic [15:0] a);
    if (a <= ROM_END) return RG_ROM;
    if (a >= IO_LO_START && a <= IO_LO_END) return RG_IOLO;
    if (a >= RAM_START && a <= RAM_END) return RG_RAM;
    if (a >= IO_HI_START) return RG_IOHI;
    return RG_RSV;
  endfunction : regionOf
endpackage : cpu_bus_pkg

// File: ram_word_mem.sv
// On-chip RAM array, 16-bit words with per-byte write enables
`timescale 1ns/1ps
module ram_word_mem (
  input  wire logic                          clk,
  input  wire logic [cpu_bus_pkg::RAM_AW-1:0] addr,
  input  wire logic [15:0]                   wdata,
  input  wire logic [1:0]                    we,
  output logic      [15:0]                   rdata
);
  import cpu_bus_pkg::*;

  // Lane 1 is the even (upper) byte; one byte array per lane keeps a single writer each
  for (genvar g = 0; g < 2; g++) begin : gLane
    logic [7:0] mem [0:(RAM_BYTES/2)-1];
    logic [7:0] rdLane_reg;
    always_ff @(posedge clk) begin
      rdLane_reg <= mem[addr];
      if (we[g]) begin
        mem[addr] <= wdata[g*8 +: 8];
      end
    end
    assign rdata[g*8 +: 8] = rdLane_reg;
  end
endmodule : ram_word_mem

// File: cpu_peripheral_bus_access.sv
// Bus access logic between the CPU and ROM, RAM and peripheral registers
// Behaviour
// [R1] Peripheral transfers use an 8-bit path
// [R2] Peripheral word write stores upper byte only
// [R3] Peripheral word read: byte in upper half
// [R4] Software should use byte peripheral accesses
// [R5] Vectors then ROM to 7FFF, two states
// [R6] F770-F77F registers: byte, three states
// [R7] FFA0-FFFF registers: byte, two/three states
// [R8] 1 KiB RAM at FB80, two states
// [R9] Bit ops: byte read, modify, write back
// [R10] Shared address: read counter, write reload
// [R11] Port read: pins for inputs, latch otherwise
// [R12] Software should keep port shadow copies
// [R13] ROM/RAM 16-bit path, two states
// [R14] Reserved accesses have no side effects
`timescale 1ns/1ps
module cpu_peripheral_bus_access (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                reqValid,
  input  wire logic                reqWrite,
  input  wire logic                reqWord,
  input  wire logic [15:0]         reqAddr,
  input  wire logic [15:0]         reqWdata,
  input  wire cpu_bus_pkg::bitop_t reqBitOp,
  input  wire logic [2:0]          reqBitNum,
  input  wire logic                reqBitVal,
  input  wire logic [15:0]         romData,
  input  wire logic [7:0]          perRdata,
  input  wire logic                perWait,
  input  wire logic [7:0]          portCIn,
  output logic                     busy,
  output logic                     respValid,
  output logic [15:0]              respRdata,
  output logic [15:0]              romAddr,
  output logic [15:0]              perAddr,
  output logic [7:0]               perWdata,
  output logic                     perRd,
  output logic                     perWr,
  output logic [7:0]               portCOut,
  output logic [7:0]               portCOe
);
  import cpu_bus_pkg::*;

  state_t      state_reg,    state_next;
  region_t     region_reg,   region_next;
  bitop_t      bitOp_reg,    bitOp_next;
  logic [1:0]  wait_reg,     wait_next;
  logic [1:0]  states_reg,   states_next;
  logic [15:0] addr_reg,     addr_next;
  logic [15:0] wdata_reg,    wdata_next;
  logic [2:0]  bitNum_reg,   bitNum_next;
  logic        bitVal_reg,   bitVal_next;
  logic        write_reg,    write_next;
  logic        word_reg,     word_next;
  logic        busy_reg,     busy_next;
  logic        resp_reg,     resp_next;
  logic [15:0] rdata_reg,    rdata_next;
  logic [15:0] romAddr_reg,  romAddr_next;
  logic [15:0] perAddr_reg,  perAddr_next;
  logic [7:0]  perWdata_reg, perWdata_next;
  logic        perRd_reg,    perRd_next;
  logic        perWr_reg,    perWr_next;
  logic [7:0]  latch_reg,    latch_next;
  logic [7:0]  dir_reg,      dir_next;
  logic [7:0]  reload_reg,   reload_next;
  logic [7:0]  count_reg,    count_next;

  logic [15:0] ramRdata;
  logic [15:0] ramWdata;
  logic [1:0]  ramWe;
  logic [15:0] ramOffset;
  logic        accept;
  logic        finish;
  logic        intReg;
  logic        ext;
  logic [7:0]  ioByte;
  logic [7:0]  rdByte;
  logic [7:0]  modByte;
  logic [7:0]  mask;
  logic        doWrite;
  logic        wrByteMode;
  logic [7:0]  wrByte;

  function automatic logic isInternal(input logic [15:0] a);
    return a == PORTC_DATA_ADDR || a == PORTC_DIR_ADDR || a == TIMER_ADDR;
  endfunction : isInternal

  assign accept    = (state_reg == ST_IDLE) && reqValid;
  assign finish    = (state_reg != ST_IDLE) && (wait_reg == 2'h1);
  assign intReg    = (region_reg == RG_IOHI) && isInternal(addr_reg);
  assign ext       = (region_reg == RG_IOLO) || ((region_reg == RG_IOHI) && !intReg);
  assign ramOffset = ((state_reg == ST_IDLE) ? reqAddr : addr_reg) - RAM_START;
  assign mask      = 8'h01 << bitNum_reg;

  ram_word_mem uRam (
    .clk   (clk),
    .addr  (ramOffset[RAM_AW:1]),
    .wdata (ramWdata),
    .we    (ramWe),
    .rdata (ramRdata)
  );

  always_comb begin
    state_next    = state_reg;
    region_next   = region_reg;
    bitOp_next    = bitOp_reg;
    wait_next     = wait_reg;
    states_next   = states_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    bitNum_next   = bitNum_reg;
    bitVal_next   = bitVal_reg;
    write_next    = write_reg;
    word_next     = word_reg;
    rdata_next    = rdata_reg;
    romAddr_next  = romAddr_reg;
    perAddr_next  = perAddr_reg;
    perWdata_next = perWdata_reg;
    latch_next    = latch_reg;
    dir_next      = dir_reg;
    reload_next   = reload_reg;
    resp_next     = 1'b0;
    doWrite       = 1'b0;
    wrByteMode    = 1'b1;
    ramWe         = 2'h0;
    ramWdata      = wdata_reg;
    // Free-running down counter sharing its address with the reload value
    count_next    = (count_reg == 8'h00) ? reload_reg : count_reg - 8'h01;
    // Live port read: input pins where direction is 0, latch where 1
    unique case (addr_reg)
      PORTC_DATA_ADDR: ioByte = (latch_reg & dir_reg) | (portCIn & ~dir_reg); // see [R11]
      PORTC_DIR_ADDR:  ioByte = WO_READ;
      TIMER_ADDR:      ioByte = count_reg; // see [R10]
      default:         ioByte = perRdata; // see [R1]
    endcase
    if (!intReg) begin
      ioByte = perRdata;
    end
    unique case (region_reg)
      RG_ROM:  rdByte = addr_reg[0] ? romData[7:0] : romData[15:8]; // see [R5]
      RG_RAM:  rdByte = addr_reg[0] ? ramRdata[7:0] : ramRdata[15:8];
      RG_RSV:  rdByte = FILL_BYTE; // see [R14]
      default: rdByte = ioByte;
    endcase
    unique case (bitOp_reg)
      BIT_SET:       modByte = rdByte | mask;
      BIT_CLEAR:     modByte = rdByte & ~mask;
      BIT_INVERT:    modByte = rdByte ^ mask;
      BIT_STORE:     modByte = bitVal_reg ? (rdByte | mask) : (rdByte & ~mask);
      BIT_STORE_INV: modByte = bitVal_reg ? (rdByte & ~mask) : (rdByte | mask);
      default:       modByte = rdByte;
    endcase

    unique case (state_reg)
      ST_IDLE: begin
        if (reqValid) begin
          region_next  = regionOf(reqAddr);
          addr_next    = reqAddr;
          wdata_next   = reqWdata;
          bitOp_next   = reqBitOp;
          bitNum_next  = reqBitNum;
          bitVal_next  = reqBitVal;
          write_next   = reqWrite && (reqBitOp == BIT_NONE);
          // Bit operations are always byte wide
          word_next    = reqWord && (reqBitOp == BIT_NONE);
          romAddr_next = reqAddr;
          perAddr_next = reqAddr;
          // Word writes to the byte bus keep only the upper byte
          perWdata_next = reqWord ? reqWdata[15:8] : reqWdata[7:0]; // see [R2]
          unique case (regionOf(reqAddr))
            RG_IOLO: states_next = IO_LO_STATES; // see [R6]
            RG_IOHI: states_next = (isInternal(reqAddr) || !perWait) ? IO_FAST_STATES
                                                                    : IO_SLOW_STATES; // see [R7]
            default: states_next = MEM_STATES; // see [R13]
          endcase
          wait_next  = states_next - 2'h1;
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        wait_next = wait_reg - 2'h1;
        if (finish) begin
          if (bitOp_reg != BIT_NONE) begin
            // Read done; write the altered byte back to the same address
            wdata_next    = {FILL_BYTE, modByte}; // see [R9]
            perWdata_next = modByte;
            write_next    = 1'b1;
            wait_next     = states_reg - 2'h1;
            state_next    = ST_RMW;
          end else begin
            doWrite    = write_reg;
            wrByteMode = !word_reg;
            resp_next  = 1'b1;
            state_next = ST_IDLE;
            if (write_reg) begin
              rdata_next = 16'h0000;
            end else if (!word_reg) begin
              rdata_next = {FILL_BYTE, rdByte};
            end else if (region_reg == RG_ROM) begin
              rdata_next = romData;
            end else if (region_reg == RG_RAM) begin
              rdata_next = ramRdata;
            end else begin
              rdata_next = {rdByte, FILL_BYTE}; // see [R3]
            end
          end
        end
      end
      ST_RMW: begin
        wait_next = wait_reg - 2'h1;
        if (finish) begin
          doWrite    = 1'b1;
          resp_next  = 1'b1;
          rdata_next = 16'h0000;
          state_next = ST_IDLE;
        end
      end
    endcase

    wrByte = word_reg ? wdata_reg[15:8] : wdata_reg[7:0];
    if (doWrite) begin
      // ROM and reserved targets simply drop the data
      if (region_reg == RG_RAM) begin
        ramWe = wrByteMode ? (addr_reg[0] ? 2'b01 : 2'b10) : 2'b11; // see [R8]
        ramWdata = wrByteMode ? {wrByte, wrByte} : wdata_reg;
      end else if (intReg) begin
        unique case (addr_reg)
          PORTC_DATA_ADDR: latch_next  = wrByte; // see [R2]
          PORTC_DIR_ADDR:  dir_next    = wrByte;
          default:         reload_next = wrByte; // see [R10]
        endcase
      end
    end
    busy_next  = state_next != ST_IDLE;
    perRd_next = (state_next == ST_ACCESS) && !write_next &&
                 ((region_next == RG_IOLO) || (region_next == RG_IOHI && !isInternal(addr_next)));
    perWr_next = (state_next != ST_IDLE) && write_next && (wait_next == 2'h1) &&
                 ((region_next == RG_IOLO) || (region_next == RG_IOHI && !isInternal(addr_next)));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      region_reg   <= RG_RSV;
      bitOp_reg    <= BIT_NONE;
      wait_reg     <= 2'h0;
      states_reg   <= MEM_STATES;
      addr_reg     <= 16'h0000;
      wdata_reg    <= 16'h0000;
      bitNum_reg   <= 3'h0;
      bitVal_reg   <= 1'b0;
      write_reg    <= 1'b0;
      word_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      resp_reg     <= 1'b0;
      rdata_reg    <= 16'h0000;
      romAddr_reg  <= 16'h0000;
      perAddr_reg  <= 16'h0000;
      perWdata_reg <= 8'h00;
      perRd_reg    <= 1'b0;
      perWr_reg    <= 1'b0;
      latch_reg    <= LATCH_RST;
      dir_reg      <= DIR_RST;
      reload_reg   <= RELOAD_RST;
      count_reg    <= RELOAD_RST;
    end else begin
      state_reg    <= state_next;
      region_reg   <= region_next;
      bitOp_reg    <= bitOp_next;
      wait_reg     <= wait_next;
      states_reg   <= states_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      bitNum_reg   <= bitNum_next;
      bitVal_reg   <= bitVal_next;
      write_reg    <= write_next;
      word_reg     <= word_next;
      busy_reg     <= busy_next;
      resp_reg     <= resp_next;
      rdata_reg    <= rdata_next;
      romAddr_reg  <= romAddr_next;
      perAddr_reg  <= perAddr_next;
      perWdata_reg <= perWdata_next;
      perRd_reg    <= perRd_next;
      perWr_reg    <= perWr_next;
      latch_reg    <= latch_next;
      dir_reg      <= dir_next;
      reload_reg   <= reload_next;
      count_reg    <= count_next;
    end
  end

  assign busy      = busy_reg;
  assign respValid = resp_reg;
  assign respRdata = rdata_reg;
  assign romAddr   = romAddr_reg;
  assign perAddr   = perAddr_reg;
  assign perWdata  = perWdata_reg;
  assign perRd     = perRd_reg;
  assign perWr     = perWr_reg;
  assign portCOut  = latch_reg;
  assign portCOe   = dir_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ext_word_upper_a: assert property (accept && reqWrite && reqWord && reqBitOp == BIT_NONE &&
    regionOf(reqAddr) == RG_IOLO |-> ##2 perWr_reg && perWdata_reg == $past(reqWdata[15:8], 2)) // see [R1]
    else $error("word write to byte bus lost upper byte");
  word_write_upper_a: assert property (accept && reqWrite && reqWord && reqBitOp == BIT_NONE &&
    reqAddr == PORTC_DATA_ADDR |-> ##2 latch_reg == $past(reqWdata[15:8], 2)) // see [R2]
    else $error("word write did not store upper byte");
  word_read_upper_a: assert property (accept && !reqWrite && reqWord && reqBitOp == BIT_NONE &&
    reqAddr == TIMER_ADDR |-> ##2 respRdata == {$past(count_reg, 1), FILL_BYTE}) // see [R3]
    else $error("word read byte not in upper half");
  rom_two_state_a: assert property (accept && regionOf(reqAddr) == RG_ROM && reqBitOp == BIT_NONE
    |-> ##1 !resp_reg ##1 resp_reg) // see [R5]
    else $error("rom access not two states");
  rom_word_path_a: assert property (accept && !reqWrite && reqWord && reqBitOp == BIT_NONE &&
    regionOf(reqAddr) == RG_ROM |-> ##2 respRdata == $past(romData, 1)) // see [R13]
    else $error("rom word read data wrong");
  iolo_three_state_a: assert property (accept && regionOf(reqAddr) == RG_IOLO && reqBitOp == BIT_NONE
    |-> ##1 !resp_reg [*2] ##1 resp_reg) // see [R6]
    else $error("low register area not three states");
  iohi_states_a: assert property (accept && regionOf(reqAddr) == RG_IOHI && reqBitOp == BIT_NONE
    |-> ##[2:3] resp_reg) // see [R7]
    else $error("high register area not two or three states");
  ram_two_state_a: assert property (accept && regionOf(reqAddr) == RG_RAM && reqBitOp == BIT_NONE
    |-> ##1 !resp_reg ##1 resp_reg) // see [R8]
    else $error("ram access not two states");
  rmw_sequence_a: assert property (accept && regionOf(reqAddr) == RG_RAM && reqBitOp != BIT_NONE
    |-> ##2 (state_reg == ST_RMW && ramWe != 2'h0) ##1 resp_reg) // see [R9]
    else $error("bit operation did not read then write");
  shared_addr_a: assert property (accept && !reqWrite && !reqWord && reqBitOp == BIT_NONE &&
    reqAddr == TIMER_ADDR |-> ##2 respRdata[7:0] == $past(count_reg, 1)) // see [R10]
    else $error("shared address read not counter");
  port_read_a: assert property (accept && !reqWrite && !reqWord && reqBitOp == BIT_NONE &&
    reqAddr == PORTC_DATA_ADDR |-> ##2 respRdata[7:0] ==
    (($past(latch_reg, 1) & $past(dir_reg, 1)) | ($past(portCIn, 1) & ~$past(dir_reg, 1)))) // see [R11]
    else $error("port read mixes pins and latch wrongly");
  reserved_quiet_a: assert property (accept && regionOf(reqAddr) == RG_RSV
    |-> ##1 (!perWr_reg && ramWe == 2'h0 && $stable(latch_reg) && $stable(dir_reg))) // see [R14]
    else $error("reserved access had a side effect");
  byte_bus_target_a: assert property ((perWr_reg || perRd_reg) |-> ext) // see [R1]
    else $error("byte bus strobe for a non-peripheral target");

  rmw_port_c: cover property (accept && reqAddr == PORTC_DATA_ADDR && reqBitOp == BIT_SET);
  word_io_write_c: cover property (accept && reqWrite && reqWord && regionOf(reqAddr) == RG_IOLO);
  slow_iohi_c: cover property (accept && regionOf(reqAddr) == RG_IOHI && perWait);
endmodule : cpu_peripheral_bus_access

// File: periph_rom_model.sv
// Behavioural ROM and external peripheral byte bus facing the bus access logic
`timescale 1ns/1ps
module periph_rom_model (
  input  wire logic        clk,
  input  wire logic [15:0] romAddr,
  input  wire logic [15:0] reqAddr,
  input  wire logic [15:0] perAddr,
  input  wire logic [7:0]  perWdata,
  input  wire logic        perRd,
  input  wire logic        perWr,
  output logic      [15:0] romData,
  output logic      [7:0]  perRdata,
  output logic             perWait
);
  logic [7:0] mem [256];
  logic [7:0] lastRd;
  int         wrCnt;

  initial begin
    wrCnt  = 0;
    lastRd = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Word depends on the word address only, so both lanes are predictable
  assign romData  = {romAddr[8:1], ~romAddr[8:1]};
  // Modules with address bit 3 set need the slow cycle
  assign perWait  = reqAddr[3];
  // Released bus shows the inverse of the last byte, never a stale match
  assign perRdata = perRd ? mem[perAddr[7:0]] : ~lastRd;

  always @(posedge clk) begin
    if (perRd) lastRd <= mem[perAddr[7:0]];
    if (perWr) begin
      mem[perAddr[7:0]] <= perWdata;
      wrCnt <= wrCnt + 1;
    end
  end
endmodule : periph_rom_model

// File: tb_top.sv
// Self-checking bench for the CPU bus access logic
`timescale 1ns/1ps
module tb_top;
  import cpu_bus_pkg::*;
  logic        clk, rstn, reqValid, reqWrite, reqWord, reqBitVal, perWait;
  logic        perRd, perWr, busy, respValid;
  logic [15:0] reqAddr, reqWdata, romData, respRdata, romAddr, perAddr, rdv;
  logic [7:0]  perRdata, portCIn, perWdata, portCOut, portCOe, d1;
  logic [2:0]  reqBitNum;
  bitop_t      reqBitOp;
  int          fails, testsRun, latv, cyc, stamp, n;

  cpu_peripheral_bus_access i_cpu_peripheral_bus_access (
    .clk(clk), .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite), .reqWord(reqWord),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqBitOp(reqBitOp), .reqBitNum(reqBitNum),
    .reqBitVal(reqBitVal), .romData(romData), .perRdata(perRdata), .perWait(perWait),
    .portCIn(portCIn), .busy(busy), .respValid(respValid), .respRdata(respRdata),
    .romAddr(romAddr), .perAddr(perAddr), .perWdata(perWdata), .perRd(perRd), .perWr(perWr),
    .portCOut(portCOut), .portCOe(portCOe));

  periph_rom_model i_periph_rom_model (
    .clk(clk), .romAddr(romAddr), .reqAddr(reqAddr), .perAddr(perAddr), .perWdata(perWdata),
    .perRd(perRd), .perWr(perWr), .romData(romData), .perRdata(perRdata), .perWait(perWait));

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : testDone

  // Latency counts falling edges after the accepting edge, so it equals states
  task automatic xfer(input logic wr, input logic wd, input logic [15:0] a, input logic [15:0] d,
                      input bitop_t op = BIT_NONE, input logic [2:0] bn = 3'h0, input logic bv = 1'b0);
    @(posedge clk);
    reqValid  <= 1'b1;
    reqWrite  <= wr;
    reqWord   <= wd;
    reqAddr   <= a;
    reqWdata  <= d;
    reqBitOp  <= op;
    reqBitNum <= bn;
    reqBitVal <= bv;
    @(posedge clk);
    reqValid <= 1'b0;
    latv = 0;
    do begin
      @(negedge clk);
      latv++;
    end while (respValid !== 1'b1 && latv < 20);
    // A response that never comes counts as a mismatch
    if (respValid !== 1'b1) begin
      check({15'h0000, respValid}, 16'h0001);
    end
    rdv   = respRdata;
    stamp = cyc;
  endtask : xfer

  task automatic ramTest();
    xfer(1, 1, RAM_START, 16'h1234);
    check(16'(latv), 16'h0002);
    xfer(0, 0, RAM_START, 16'h0000);
    check(rdv, 16'h0012);
    xfer(0, 0, RAM_START + 16'h0001, 16'h0000);
    check(rdv, 16'h0034);
    xfer(1, 0, RAM_START + 16'h0001, 16'h00AB);
    xfer(0, 1, RAM_START, 16'h0000);
    check(rdv, 16'h12AB);
    check(16'(latv), 16'h0002);
    xfer(1, 1, RAM_END - 16'h0001, 16'hBEEF);
    xfer(0, 1, RAM_END - 16'h0001, 16'h0000);
    check(rdv, 16'hBEEF);
  endtask : ramTest

  task automatic romTest();
    xfer(0, 1, ROM_START, 16'h0000);
    check(rdv, 16'h18E7);
    check(16'(latv), 16'h0002);
    xfer(0, 0, VEC_END, 16'h0000);
    check(rdv, 16'h00E8);
    xfer(0, 1, ROM_END - 16'h0001, 16'h0000);
    check(rdv, 16'hFF00);
  endtask : romTest

  task automatic ioTest();
    xfer(1, 0, IO_LO_START, 16'h003C);
    check(16'(latv), 16'h0003);
    check({8'h00, i_periph_rom_model.mem[8'h70]}, 16'h003C);
    xfer(0, 0, IO_LO_START, 16'h0000);
    check(rdv, 16'h003C);
    xfer(1, 1, IO_LO_END - 16'h0001, 16'h5566);
    check({i_periph_rom_model.mem[8'h7E], i_periph_rom_model.mem[8'h7F]}, 16'h5500);
    xfer(0, 1, IO_LO_END - 16'h0001, 16'h0000);
    check(rdv, 16'h5500);
    xfer(1, 0, IO_HI_START, 16'h00C3);
    check(16'(latv), 16'h0002);
    xfer(0, 0, IO_HI_START, 16'h0000);
    check(rdv, 16'h00C3);
    xfer(1, 0, 16'hFFA8, 16'h0096);
    check(16'(latv), 16'h0003);
    xfer(0, 0, 16'hFFA8, 16'h0000);
    check(rdv, 16'h0096);
  endtask : ioTest

  task automatic rsvTest();
    n = i_periph_rom_model.wrCnt;
    xfer(1, 0, RSV_START, 16'h0077);
    xfer(1, 1, 16'hF800, 16'h7777);
    xfer(0, 0, RSV_START, 16'h0000);
    check(rdv, 16'h0000);
    check(16'(i_periph_rom_model.wrCnt - n), 16'h0000);
    xfer(0, 1, RAM_START, 16'h0000);
    check(rdv, 16'h12AB);
  endtask : rsvTest

  task automatic bitTest();
    bitop_t     ops [5] = '{BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_STORE, BIT_STORE_INV};
    logic [2:0] bns [5] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h0};
    logic       bvs [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] exs [5] = '{8'h5B, 8'h59, 8'hD9, 8'hDD, 8'hDC};
    xfer(1, 0, 16'hFB90, 16'h005A);
    foreach (ops[i]) begin
      xfer(0, 0, 16'hFB90, 16'h0000, ops[i], bns[i], bvs[i]);
      check(16'(latv), 16'h0003);
      xfer(0, 0, 16'hFB90, 16'h0000);
      check(rdv, {8'h00, exs[i]});
    end
  endtask : bitTest

  task automatic portTest();
    xfer(1, 0, PORTC_DIR_ADDR, 16'h003F);
    check({8'h00, portCOe}, 16'h003F);
    xfer(0, 0, PORTC_DIR_ADDR, 16'h0000);
    check(rdv, 16'h00FF);
    xfer(1, 0, PORTC_DATA_ADDR, 16'h0080);
    check({8'h00, portCOut}, 16'h0080);
    xfer(0, 0, PORTC_DATA_ADDR, 16'h0000);
    check(rdv, 16'h0055 & 16'h00C0 | 16'h0080 & 16'h003F);
    xfer(0, 0, PORTC_DATA_ADDR, 16'h0000, BIT_SET, 3'h0, 1'b0);
    check({8'h00, portCOut}, 16'h0041);
    xfer(0, 0, PORTC_DIR_ADDR, 16'h0000, BIT_CLEAR, 3'h0, 1'b0);
    check({8'h00, portCOe}, 16'h00FE);
    // Shadow copy in RAM avoids folding pin levels into the latch
    xfer(1, 0, 16'hFBA0, 16'h0080);
    xfer(0, 0, 16'hFBA0, 16'h0000, BIT_SET, 3'h0, 1'b0);
    xfer(0, 0, 16'hFBA0, 16'h0000);
    xfer(1, 0, PORTC_DATA_ADDR, rdv);
    check({8'h00, portCOut}, 16'h0081);
    xfer(1, 1, PORTC_DATA_ADDR, 16'h24C3);
    check({8'h00, portCOut}, 16'h0024);
  endtask : portTest

  task automatic timerTest();
    xfer(1, 0, TIMER_ADDR, 16'h00FF);
    xfer(0, 0, TIMER_ADDR, 16'h0000);
    d1 = rdv[7:0];
    n  = stamp;
    xfer(0, 0, TIMER_ADDR, 16'h0000);
    check({8'h00, 8'(d1 - rdv[7:0])}, {8'h00, 8'(stamp - n)});
    xfer(1, 0, TIMER_ADDR, 16'h0003);
    repeat (300) @(posedge clk);
    xfer(0, 0, TIMER_ADDR, 16'h0000);
    check({15'h0000, rdv[7:0] <= 8'h03}, 16'h0001);
    xfer(0, 1, TIMER_ADDR, 16'h0000);
    check({7'h00, rdv[15:8] <= 8'h03, rdv[7:0]}, 16'h0100);
  endtask : timerTest

  initial begin
    #(20 * 20000);
    fails++;
    $display("[ERR] %0t seen %h expected %h", $time, 16'h0000, 16'h0001);
    testDone();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqWord = 1'b0;
    reqAddr = 16'h0000;
    reqWdata = 16'h0000;
    reqBitOp = BIT_NONE;
    reqBitNum = 3'h0;
    reqBitVal = 1'b0;
    portCIn = 8'h55;
    fails = 0;
    testsRun = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({portCOut, portCOe}, 16'h0000);
    check({15'h0000, busy}, 16'h0000);
    ramTest();
    romTest();
    ioTest();
    rsvTest();
    bitTest();
    portTest();
    timerTest();
    testDone();
  end
endmodule : tb_top
